// File: rtl/uic_consts.svh
/*
 * Register indices, byte addresses, field positions and reset values of the
 * U-interface control register block.
 * Assumes inclusion by bare name from files that use these macros.
 */
`ifndef UIC_CONSTS_SVH
`define UIC_CONSTS_SVH

// ==========================================================================
// register indices and byte addresses (byte address is four times index)
`define UIC_IDX_UCTL   4'h1
`define UIC_IDX_STCTL  4'h2
`define UIC_IDX_OVH    4'h3

// ==========================================================================
// u_interface_control fields
`define UIC_B_LOOP     0
`define UIC_B_PS_SND   1
`define UIC_B_PS_FST   2
`define UIC_B_NTM      3
`define UIC_B_ACT      4
`define UIC_B_TRANSP   5
`define UIC_B_SAI_LO   6
`define UIC_B_SAI_HI   7

// s/t control: only the tdm bus select bit lives in this block
`define UIC_B_TDM      5

// ==========================================================================
// reset values
`define UIC_UCTL_RST   8'hef
`define UIC_TDM_RST    1'h1
`define UIC_OVH_RST    6'h39

// ==========================================================================
// axi responses
`define UIC_RESP_OKAY  2'h0
`define UIC_RESP_SLV   2'h2

`endif

// File: rtl/uic_pkg.sv
/*
 * Types of the U-interface control register block.
 * Assumes nothing of its surroundings.
 */
package uic_pkg;

	// ==================================================================
	// overhead bits handed to the framer, latched once per frame
	typedef struct packed {
		logic power_status_first;
		logic power_status_second;
		logic ntm;
		logic act;
		logic sai;
		logic transparency_enable_n;
	} uic_ovh_s;

	// ==================================================================
	// activity indicator field modes
	typedef enum logic [1:0] {
		SAI_FORCE0 = 2'b00,
		SAI_FORCE1 = 2'b01,
		SAI_AUTO_A = 2'b10,
		SAI_AUTO_B = 2'b11
	} uic_sai_e;

endpackage

// File: rtl/uic_top.sv
/*
 * U-interface control register with AXI4-Lite slave and per-frame overhead
 * latch for the transmit framer.
 * Assumes i_frame_start, i_st_activity come from logic on i_clk; power
 * status pins come from outside and are synchronised here.
 */
// Function
// - readable writable 8-bit control register, index 01h
// - bit0 low: analog loopback, canceler off, scrambler match
// - bit1 drives second power bit if tdm select low
// - bit2 drives first power bit if tdm select low
// - power bits 11 mean all normal, default
// - bit3 sets transmitted test-mode bit, default one
// - bit4 sets transmitted activation bit, default zero
// - bit5 low enables transmit data transparency
// - bits7-6 force indicator 0, 1, or derive internally
// - derived indicator follows s/t INFO1/INFO3 activity
// - tdm select bit5 at index 02h, default one
`timescale 1ns/1ps
`default_nettype none
`include "uic_consts.svh"

module uic_top #(
	parameter int ADDR_W = 4
) (
	input  wire logic                  i_clk,
	input  wire logic                  i_arst_n,
	input  wire logic [ADDR_W-1:0]     i_s_axi_awaddr,
	input  wire logic                  i_s_axi_awvalid,
	output logic                       o_s_axi_awready,
	input  wire logic [31:0]           i_s_axi_wdata,
	input  wire logic [3:0]            i_s_axi_wstrb,
	input  wire logic                  i_s_axi_wvalid,
	output logic                       o_s_axi_wready,
	output logic [1:0]                 o_s_axi_bresp,
	output logic                       o_s_axi_bvalid,
	input  wire logic                  i_s_axi_bready,
	input  wire logic [ADDR_W-1:0]     i_s_axi_araddr,
	input  wire logic                  i_s_axi_arvalid,
	output logic                       o_s_axi_arready,
	output logic [31:0]                o_s_axi_rdata,
	output logic [1:0]                 o_s_axi_rresp,
	output logic                       o_s_axi_rvalid,
	input  wire logic                  i_s_axi_rready,
	input  wire logic                  i_frame_start,
	input  wire logic                  i_st_activity,
	input  wire logic                  i_ps_first_pin,
	input  wire logic                  i_ps_second_pin,
	output uic_pkg::uic_ovh_s          o_ovh,
	output logic                       o_loopback_n,
	output logic                       o_echo_cancel_en,
	output logic                       o_rx_scram_match,
	output logic                       o_tdm_bus_select_n
);

	// ==================================================================
	// elaboration check
	generate
		if (ADDR_W < 4) begin : g_bad_addr
			$error("uic_top: ADDR_W must be at least 4");
		end
	endgenerate

	// ==================================================================
	// address decode, shared by write and read paths
	// returns {ovh, stctl, uctl} one-hot, zero when unmapped
	function automatic logic [2:0] uic_sel(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-3:0] idx;
		idx = a[ADDR_W-1:2];
		uic_sel = {idx == (ADDR_W-2)'(`UIC_IDX_OVH),
			idx == (ADDR_W-2)'(`UIC_IDX_STCTL),
			idx == (ADDR_W-2)'(`UIC_IDX_UCTL)};
	endfunction

	// ==================================================================
	// pin synchronisers
	logic [1:0] ps_meta_reg;
	logic [1:0] ps_sync_reg;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ps_meta_reg <= 2'h3;
			ps_sync_reg <= 2'h3;
		end else begin
			ps_meta_reg <= {i_ps_first_pin, i_ps_second_pin};
			ps_sync_reg <= ps_meta_reg;
		end
	end

	// ==================================================================
	// axi write channel and registers
	logic              aw_full_reg, aw_full_next;
	logic              w_full_reg, w_full_next;
	logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
	logic [7:0]        wdata_reg, wdata_next;
	logic              wstrb_reg, wstrb_next;
	logic              awready_reg, awready_next;
	logic              wready_reg, wready_next;
	logic              bvalid_reg, bvalid_next;
	logic [1:0]        bresp_reg, bresp_next;
	logic [7:0]        uctl_reg, uctl_next;
	logic              tdm_reg, tdm_next;
	logic              loopback_n_reg, loopback_n_next;
	logic              scram_match_reg, scram_match_next;
	logic              commit;
	logic [2:0]        wsel;

	always_comb begin
		aw_full_next = aw_full_reg;
		w_full_next  = w_full_reg;
		awaddr_next  = awaddr_reg;
		wdata_next   = wdata_reg;
		wstrb_next   = wstrb_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		uctl_next    = uctl_reg;
		tdm_next     = tdm_reg;
		wsel         = uic_sel(awaddr_reg);
		commit       = aw_full_reg && w_full_reg && !bvalid_reg;
		if (i_s_axi_awvalid && awready_reg) begin
			aw_full_next = 1'b1;
			awaddr_next  = i_s_axi_awaddr;
		end
		if (i_s_axi_wvalid && wready_reg) begin
			w_full_next = 1'b1;
			wdata_next  = i_s_axi_wdata[7:0];
			wstrb_next  = i_s_axi_wstrb[0];
		end
		if (bvalid_reg && i_s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		if (commit) begin
			aw_full_next = 1'b0;
			w_full_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = (wsel == 3'h0) ? `UIC_RESP_SLV : `UIC_RESP_OKAY;
			if (wsel[0] && wstrb_reg) begin
				uctl_next = wdata_reg;
			end
			if (wsel[1] && wstrb_reg) begin
				tdm_next = wdata_reg[`UIC_B_TDM];
			end
		end
		awready_next = !aw_full_next;
		wready_next  = !w_full_next;
		loopback_n_next  = uctl_next[`UIC_B_LOOP];
		scram_match_next = !uctl_next[`UIC_B_LOOP];
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			aw_full_reg <= 1'b0;
			w_full_reg  <= 1'b0;
			awaddr_reg  <= '0;
			wdata_reg   <= 8'h00;
			wstrb_reg   <= 1'b0;
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= `UIC_RESP_OKAY;
			uctl_reg    <= `UIC_UCTL_RST;
			tdm_reg     <= `UIC_TDM_RST;
			loopback_n_reg  <= 1'(`UIC_UCTL_RST >> `UIC_B_LOOP);
			scram_match_reg <= ~1'(`UIC_UCTL_RST >> `UIC_B_LOOP);
		end else begin
			aw_full_reg <= aw_full_next;
			w_full_reg  <= w_full_next;
			awaddr_reg  <= awaddr_next;
			wdata_reg   <= wdata_next;
			wstrb_reg   <= wstrb_next;
			awready_reg <= awready_next;
			wready_reg  <= wready_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			uctl_reg    <= uctl_next;
			tdm_reg     <= tdm_next;
			loopback_n_reg  <= loopback_n_next;
			scram_match_reg <= scram_match_next;
		end
	end

	// ==================================================================
	// per-frame overhead latch
	// the framer samples o_ovh for a whole frame, so bits change only on
	// the frame strobe and a write mid-frame never tears an overhead word
	uic_pkg::uic_ovh_s ovh_reg, ovh_next, ovh_live;

	always_comb begin
		ovh_live.ntm                   = uctl_reg[`UIC_B_NTM];
		ovh_live.act                   = uctl_reg[`UIC_B_ACT];
		ovh_live.transparency_enable_n = uctl_reg[`UIC_B_TRANSP];
		// with no tdm bus the power status pins take over
		if (tdm_reg) begin
			ovh_live.power_status_first  = ps_sync_reg[1];
			ovh_live.power_status_second = ps_sync_reg[0];
		end else begin
			ovh_live.power_status_first  = uctl_reg[`UIC_B_PS_FST];
			ovh_live.power_status_second = uctl_reg[`UIC_B_PS_SND];
		end
		case (uic_pkg::uic_sai_e'(uctl_reg[`UIC_B_SAI_HI:`UIC_B_SAI_LO]))
			uic_pkg::SAI_FORCE0: ovh_live.sai = 1'b0;
			uic_pkg::SAI_FORCE1: ovh_live.sai = 1'b1;
			default:             ovh_live.sai = i_st_activity;
		endcase
		ovh_next = i_frame_start ? ovh_live : ovh_reg;
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ovh_reg <= `UIC_OVH_RST;
		end else begin
			ovh_reg <= ovh_next;
		end
	end

	// ==================================================================
	// axi read channel
	logic        arready_reg, arready_next;
	logic        rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0]  rresp_reg, rresp_next;
	logic [2:0]  rsel;

	always_comb begin
		rvalid_next = rvalid_reg;
		rdata_next  = rdata_reg;
		rresp_next  = rresp_reg;
		rsel        = uic_sel(i_s_axi_araddr);
		if (rvalid_reg && i_s_axi_rready) begin
			rvalid_next = 1'b0;
		end
		if (i_s_axi_arvalid && arready_reg) begin
			rvalid_next = 1'b1;
			rresp_next  = `UIC_RESP_OKAY;
			case (rsel)
				3'h1:    rdata_next = {24'h0, uctl_reg};
				3'h2:    rdata_next = {26'h0, tdm_reg, 5'h0};
				3'h4:    rdata_next = {26'h0, ovh_reg};
				default: begin
					rdata_next = 32'h0;
					rresp_next = `UIC_RESP_SLV;
				end
			endcase
		end
		arready_next = !rvalid_next;
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0;
			rresp_reg   <= `UIC_RESP_OKAY;
		end else begin
			arready_reg <= arready_next;
			rvalid_reg  <= rvalid_next;
			rdata_reg   <= rdata_next;
			rresp_reg   <= rresp_next;
		end
	end

	// ==================================================================
	// outputs
	assign o_s_axi_awready    = awready_reg;
	assign o_s_axi_wready     = wready_reg;
	assign o_s_axi_bvalid     = bvalid_reg;
	assign o_s_axi_bresp      = bresp_reg;
	assign o_s_axi_arready    = arready_reg;
	assign o_s_axi_rvalid     = rvalid_reg;
	assign o_s_axi_rdata      = rdata_reg;
	assign o_s_axi_rresp      = rresp_reg;
	assign o_ovh              = ovh_reg;
	assign o_loopback_n       = loopback_n_reg;
	assign o_echo_cancel_en   = loopback_n_reg;
	assign o_rx_scram_match   = scram_match_reg;
	assign o_tdm_bus_select_n = tdm_reg;

	// ==================================================================
	// assertions
	sequence s_frame;
		i_frame_start;
	endsequence

	sequence s_ucommit;
		commit && wsel[0] && wstrb_reg;
	endsequence

	a_uctl_write: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		s_ucommit |=> uctl_reg == $past(wdata_reg) && o_s_axi_bvalid)
		else $error("control register write lost");

	a_loop_ctrl: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		s_ucommit ##0 !wdata_reg[0] |=> !o_echo_cancel_en && o_rx_scram_match && !o_loopback_n)
		else $error("loopback controls wrong");

	a_ps_reg: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		s_frame ##0 !tdm_reg |=> o_ovh.power_status_second == $past(uctl_reg[1])
			&& o_ovh.power_status_first == $past(uctl_reg[2]))
		else $error("power status not from register");

	a_ps_pin: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		s_frame ##0 tdm_reg |=> o_ovh.power_status_first == $past(ps_sync_reg[1])
			&& o_ovh.power_status_second == $past(ps_sync_reg[0]))
		else $error("power status register not ignored");

	a_ntm_act: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		s_frame |=> o_ovh.ntm == $past(uctl_reg[3]) && o_ovh.act == $past(uctl_reg[4]))
		else $error("test mode or activation bit wrong");

	a_transp_bit: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		s_frame |=> o_ovh.transparency_enable_n == $past(uctl_reg[5]))
		else $error("transparency bit wrong");

	a_sai_force: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		s_frame ##0 !uctl_reg[7] |=> o_ovh.sai == $past(uctl_reg[6]))
		else $error("forced activity indicator wrong");

	a_sai_auto: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		s_frame ##0 uctl_reg[7] |=> o_ovh.sai == $past(i_st_activity))
		else $error("derived activity indicator wrong");

	a_tdm_write: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		commit && wsel[1] && wstrb_reg |=> o_tdm_bus_select_n == $past(wdata_reg[5]))
		else $error("tdm select write lost");

	a_ovh_hold: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		!i_frame_start |=> $stable(o_ovh))
		else $error("overhead changed mid frame");

endmodule
`default_nettype wire

// File: tb/uic_framer_model.sv
/*
 * Behavioural model of the transmit framer and S/T side feeding the block.
 * Assumes the bench raises i_req to ask for frame pulses on i_clk.
 */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// framer model
module uic_framer_model (
	input  wire logic       i_clk,
	input  wire logic       i_arst_n,
	input  wire logic       i_req,
	input  wire logic       i_info_on,
	input  wire logic [1:0] i_pins,
	output logic            o_frame_start,
	output logic            o_st_activity,
	output logic            o_ps_first_pin,
	output logic            o_ps_second_pin
);
	logic [1:0] gap_reg;

	// pulses come only every fourth cycle, so a request waits one to four cycles for its pulse
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			gap_reg       <= 2'h0;
			o_frame_start <= 1'b0;
		end else begin
			gap_reg       <= gap_reg + 2'h1;
			o_frame_start <= i_req && (gap_reg == 2'h3);
		end
	end

	assign o_st_activity = i_info_on;
	assign o_ps_first_pin  = i_pins[1];
	assign o_ps_second_pin = i_pins[0];
endmodule
`default_nettype wire

// File: tb/uic_top_tb.sv
/*
 * Self-checking bench for the U-interface control register block.
 * Assumes the framer model file and a 25 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module uic_top_tb;
	logic              clk = 1'b0;
	logic              arst_n = 1'b0;
	logic [3:0]        awaddr = 4'h0;
	logic [3:0]        araddr = 4'h0;
	logic [31:0]       wdata = 32'h0;
	logic              awvalid = 1'b0;
	logic              wvalid = 1'b0;
	logic              bready = 1'b0;
	logic              arvalid = 1'b0;
	logic              rready = 1'b0;
	logic              req = 1'b0;
	logic              info_on = 1'b0;
	logic [1:0]        pins = 2'h3;
	logic [31:0]       rdata;
	logic [1:0]        bresp, rresp;
	logic              awready, wready, bvalid, arready, rvalid;
	logic              frame_start, st_act, ps_first_pin, ps_second_pin;
	logic              loop_n, echo_en, scram_m, tdm_n;
	uic_pkg::uic_ovh_s ovh;
	int                num_errors = 0;
	int                tests_run = 0;

	always #20 clk = ~clk;

	uic_top #(.ADDR_W(4)) dut (.i_clk(clk), .i_arst_n(arst_n),
		.i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
		.i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wvalid),
		.o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
		.i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
		.o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
		.o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .i_frame_start(frame_start),
		.i_st_activity(st_act), .i_ps_first_pin(ps_first_pin),
		.i_ps_second_pin(ps_second_pin), .o_ovh(ovh),
		.o_loopback_n(loop_n), .o_echo_cancel_en(echo_en), .o_rx_scram_match(scram_m),
		.o_tdm_bus_select_n(tdm_n));

	uic_framer_model far (.i_clk(clk), .i_arst_n(arst_n), .i_req(req), .i_info_on(info_on),
		.i_pins(pins), .o_frame_start(frame_start), .o_st_activity(st_act),
		.o_ps_first_pin(ps_first_pin), .o_ps_second_pin(ps_second_pin));

	// ======================================================================
	// bus tasks and checks
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// write address and data go out together; bready stays up until the answer
	task automatic axi_wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
		@(posedge clk);
		awaddr  <= a;
		wdata   <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		// only the watchdog ends a wait that never gets its answer
		do begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic test_done();
		if (num_errors == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ======================================================================
	// watchdog: the whole run needs well under a thousand cycles
	initial begin
		#(40 * 5000);
		num_errors++;
		test_done();
	end

	// ======================================================================
	// test sequence
	initial begin
		logic [1:0]  resp;
		logic [31:0] d;
		logic [7:0]  c;
		logic [5:0]  exp_ovh, prev_ovh;
		logic        info;
		prev_ovh = 6'h39;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		chk({30'h0, loop_n, echo_en, scram_m, tdm_n}, 34'hd);
		chk({31'h0, awready, wready, arready}, 34'h7);
		chk({28'h0, ovh}, 34'h39);
		axi_rd(4'h4, d, resp);
		chk({resp, d}, 34'hef);
		axi_rd(4'h8, d, resp);
		chk({resp, d}, 34'h20);
		axi_wr(4'h4, 8'hee, resp);
		chk({resp, 29'h0, loop_n, echo_en, scram_m}, 34'h1);
		axi_wr(4'h4, 8'hef, resp);
		chk({resp, 29'h0, loop_n, echo_en, scram_m}, 34'h6);
		// index 0 is unmapped: refused and harmless
		axi_wr(4'h0, 8'h00, resp);
		chk({resp, 32'h0}, {2'h2, 32'h0});
		axi_rd(4'h0, d, resp);
		chk({resp, d}, {2'h2, 32'h0});
		axi_rd(4'h4, d, resp);
		chk({resp, d}, 34'hef);
		// every field code, tdm select both ways, pins opposite to the register
		for (int k = 0; k < 32; k++) begin
			c = {k[1:0], k[2], k[0], k[1], k[3:2], 1'b1};
			info = k[3] ^ k[0];
			pins <= ~k[3:2];
			info_on <= info;
			axi_wr(4'h8, {2'h0, k[4], 5'h0}, resp);
			chk({33'h0, tdm_n}, {33'h0, k[4]});
			axi_wr(4'h4, c, resp);
			chk({resp, 32'h0}, 34'h0);
			axi_rd(4'h4, d, resp);
			chk({resp, d}, {26'h0, c});
			chk({28'h0, ovh}, {28'h0, prev_ovh});
			exp_ovh = {k[4] ? ~k[3] : c[2], k[4] ? ~k[2] : c[1], c[3], c[4],
				c[7] ? info : c[6], c[5]};
			req <= 1'b1;
			do begin
				@(posedge clk);
			end while (frame_start !== 1'b1);
			req <= 1'b0;
			@(posedge clk);
			chk({28'h0, ovh}, {28'h0, exp_ovh});
			// the status index shows the overhead word that the framer holds
			axi_rd(4'hc, d, resp);
			chk({resp, d}, {28'h0, exp_ovh});
			prev_ovh = exp_ovh;
		end
		test_done();
	end
endmodule
`default_nettype wire
